/* hdl/ict_pkg.sv */
// Constants, register map and helpers for the interval compare timer
package ict_pkg;

   // Channel count and data widths
   localparam int ICT_NCH = 2;
   localparam int ICT_DW = 16;
   localparam int ICT_AW = 4;
   localparam int ICT_BE_W = 2;

   // Register byte offsets; each channel owns one stride of the map
   localparam logic [3:0] ICT_RUN_OFS = 4'h0;
   localparam logic [3:0] ICT_CSR_OFS = 4'h2;
   localparam logic [3:0] ICT_CNT_OFS = 4'h4;
   localparam logic [3:0] ICT_LIM_OFS = 4'h6;
   localparam int ICT_CH_STRIDE = 8;

   // Reset values
   localparam logic [15:0] ICT_RUN_RST = 16'h0000;
   localparam logic [15:0] ICT_CNT_RST = 16'h0000;
   localparam logic [15:0] ICT_LIM_RST = 16'hFFFF;
   localparam logic ICT_FLAG_RST = 1'b0;
   localparam logic ICT_IE_RST = 1'b0;
   localparam logic [1:0] ICT_CKS_RST = 2'h0;

   // Field positions of the control/status register
   localparam int ICT_FLAG_BIT = 7;
   localparam int ICT_IE_BIT = 6;
   localparam int ICT_CKS_HI = 1;
   localparam int ICT_CKS_LO = 0;
   localparam int ICT_CKS_W = 2;
   localparam int ICT_NSEL = 4;

   // Field positions of the run register
   localparam int ICT_RUN_CH0_BIT = 0;
   localparam int ICT_RUN_CH1_BIT = 1;

   // Free prescaler width, enough for the slowest division of 512
   localparam int ICT_PRE_W = 9;
   localparam int ICT_DIV_BASE_LOG2 = 3;
   localparam int ICT_DIV_STEP_LOG2 = 2;

   // Division selected by a clock select value, as a power of two
   function automatic int ict_div_log2(input int sel);
      return ICT_DIV_BASE_LOG2 + ICT_DIV_STEP_LOG2 * sel;
   endfunction

   // Merge written bytes over the old value; unselected bytes stay
   function automatic logic [15:0] ict_merge(
      input logic [15:0] old_val,
      input logic [15:0] new_val,
      input logic [1:0] be
   );
      logic [15:0] res;
      res = old_val;
      if (be[0])
      begin
         res[7:0] = new_val[7:0];
      end
      if (be[1])
      begin
         res[15:8] = new_val[15:8];
      end
      return res;
   endfunction

endpackage

/* hdl/ict_prescaler.sv */
// Free-running prescaler giving one-cycle ticks at clk/8, /32, /128, /512
`timescale 1ns/1ps
`default_nettype none
module ict_prescaler
   import ict_pkg::*;
#(
   parameter int PRE_W = ICT_PRE_W
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic standby_in,
   output logic [ICT_NSEL-1:0] tick
);

   logic [PRE_W-1:0] pre_reg;
   logic [PRE_W-1:0] pre_next;

   assign pre_next = pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};

   always_ff @(posedge clk_sys)
   begin
      if (reset || standby_in)
      begin
         pre_reg <= '0;
      end
      else
      begin
         pre_reg <= pre_next;
      end
   end

   genvar s;
   generate
      for (s = 0; s < ICT_NSEL; s++)
      begin : g_tick
         localparam int L = ict_div_log2(s);
         always_ff @(posedge clk_sys)
         begin
            if (reset || standby_in)
            begin
               tick[s] <= 1'b0;
            end
            else
            begin
               tick[s] <= &pre_reg[L-1:0];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

/* hdl/ict_timer.sv */
// Two-channel 16-bit interval compare timer with register port
//
// Overview of operation
// - Control/status register clears to zero on reset and standby entry.
// - Reserved status bits 15:8 and 5:2 read zero; software writes zero.
// - Bit 7 match flag set by match; write zero clears, one keeps.
// - Interrupt request is high while match flag and enable are both one.
// - Clock select 00,01,10,11 picks clock divided by 8, 32, 128, 512.
// - Counter is 16-bit up-counter, steps each selected tick while running.
// - On counter equal to limit, counter clears, flag sets, counting continues.
// - Counter resets to zero on reset and standby entry.
// - Limit register is 16-bit writable, all ones after reset and standby.
// - Match acts on the tick after equality, as counter rolls to zero.
// - Match clear beats a same-cycle counter write; written value discarded.
// - Word write beats a same-cycle increment; increment is dropped.
// - Byte write beats increment; other byte keeps its old value.
// - Each channel drives its own interrupt request line.
// - Two independent channels with own counter, limit and status register.
// - Shared run register, bit per channel, resets to zero.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ict_timer
   import ict_pkg::*;
#(
   parameter int NCH = ICT_NCH,
   parameter int DW = ICT_DW
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic standby_in,
   input wire logic [ICT_AW-1:0] reg_addr,
   input wire logic [DW-1:0] reg_wdata,
   input wire logic [ICT_BE_W-1:0] reg_be,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DW-1:0] reg_rdata,
   output logic [NCH-1:0] match_interrupt
);

   // Shared divider ticks
   logic [ICT_NSEL-1:0] tick;

   // Run register and its decode
   logic [NCH-1:0] count_run_bit_reg;
   logic run_sel;

   // Per-channel state
   logic [DW-1:0] interval_counter_reg [NCH];
   logic [DW-1:0] interval_limit_reg [NCH];
   logic [NCH-1:0] match_flag_reg;
   logic [NCH-1:0] match_irq_enable_reg;
   logic [ICT_CKS_W-1:0] cks_reg [NCH];
   logic [NCH-1:0] static_chk_reg;

   // Per-channel decode and events
   logic [NCH-1:0] csr_sel;
   logic [NCH-1:0] cnt_sel;
   logic [NCH-1:0] lim_sel;
   logic [NCH-1:0] count_tick;
   logic [NCH-1:0] match_hit;
   logic [NCH-1:0] static_hit;
   logic [NCH-1:0] flag_clear;

   // Read path
   logic [DW-1:0] rd_mux;

   ict_prescaler #(
      .PRE_W(ICT_PRE_W)
   ) u_prescaler (
      .clk_sys(clk_sys),
      .reset(reset),
      .standby_in(standby_in),
      .tick(tick)
   );

   assign run_sel = (reg_addr == ICT_RUN_OFS);

   always_ff @(posedge clk_sys)
   begin
      if (reset || standby_in)
      begin
         count_run_bit_reg <= ICT_RUN_RST[NCH-1:0];
      end
      else if (reg_wr && run_sel && reg_be[0])
      begin
         count_run_bit_reg <= reg_wdata[NCH-1:0];
      end
   end

   genvar c;
   generate
      for (c = 0; c < NCH; c++)
      begin : g_ch
         localparam logic [3:0] CH_BASE = 4'(c * ICT_CH_STRIDE);

         assign csr_sel[c] = (reg_addr == (CH_BASE | ICT_CSR_OFS));
         assign cnt_sel[c] = (reg_addr == (CH_BASE | ICT_CNT_OFS));
         assign lim_sel[c] = (reg_addr == (CH_BASE | ICT_LIM_OFS));

         assign count_tick[c] = count_run_bit_reg[c] && tick[cks_reg[c]];

         assign match_hit[c] = count_tick[c]
            && (interval_counter_reg[c] == interval_limit_reg[c]);

         assign static_hit[c] = static_chk_reg[c]
            && !count_run_bit_reg[c]
            && (interval_counter_reg[c] == interval_limit_reg[c]);

         assign flag_clear[c] = reg_wr && csr_sel[c] && reg_be[0]
            && !reg_wdata[ICT_FLAG_BIT];

         // Compare after a write to a stopped channel, once values settle
         always_ff @(posedge clk_sys)
         begin
            if (reset || standby_in)
            begin
               static_chk_reg[c] <= 1'b0;
            end
            else
            begin
               static_chk_reg[c] <= reg_wr && !count_run_bit_reg[c]
                  && (cnt_sel[c] || lim_sel[c]);
            end
         end

         always_ff @(posedge clk_sys)
         begin
            if (reset || standby_in)
            begin
               interval_counter_reg[c] <= ICT_CNT_RST;
            end
            else if (match_hit[c] || static_hit[c])
            begin
               interval_counter_reg[c] <= ICT_CNT_RST;
            end
            else if (reg_wr && cnt_sel[c])
            begin
               interval_counter_reg[c] <= ict_merge(interval_counter_reg[c],
                  reg_wdata, reg_be);
            end
            else if (count_tick[c])
            begin
               interval_counter_reg[c] <= interval_counter_reg[c]
                  + {{(DW-1){1'b0}}, 1'b1};
            end
         end

         always_ff @(posedge clk_sys)
         begin
            if (reset || standby_in)
            begin
               interval_limit_reg[c] <= ICT_LIM_RST;
            end
            else if (reg_wr && lim_sel[c])
            begin
               interval_limit_reg[c] <= ict_merge(interval_limit_reg[c],
                  reg_wdata, reg_be);
            end
         end

         always_ff @(posedge clk_sys)
         begin
            if (reset || standby_in)
            begin
               match_flag_reg[c] <= ICT_FLAG_RST;
            end
            // Set wins so a match in the clearing cycle is not lost
            else if (match_hit[c] || static_hit[c])
            begin
               match_flag_reg[c] <= 1'b1;
            end
            else if (flag_clear[c])
            begin
               match_flag_reg[c] <= 1'b0;
            end
         end

         always_ff @(posedge clk_sys)
         begin
            if (reset || standby_in)
            begin
               match_irq_enable_reg[c] <= ICT_IE_RST;
               cks_reg[c] <= ICT_CKS_RST;
            end
            else if (reg_wr && csr_sel[c] && reg_be[0])
            begin
               match_irq_enable_reg[c] <= reg_wdata[ICT_IE_BIT];
               cks_reg[c] <= reg_wdata[ICT_CKS_HI:ICT_CKS_LO];
            end
         end

         assign match_interrupt[c] = match_flag_reg[c]
            && match_irq_enable_reg[c];
      end
   endgenerate

   // Read multiplexer; unmapped addresses return zero
   always_comb
   begin
      rd_mux = '0;
      if (run_sel)
      begin
         rd_mux[NCH-1:0] = count_run_bit_reg;
      end
      for (int k = 0; k < NCH; k++)
      begin
         if (csr_sel[k])
         begin
            rd_mux[ICT_FLAG_BIT] = match_flag_reg[k];
            rd_mux[ICT_IE_BIT] = match_irq_enable_reg[k];
            rd_mux[ICT_CKS_HI:ICT_CKS_LO] = cks_reg[k];
         end
         if (cnt_sel[k])
         begin
            rd_mux = interval_counter_reg[k];
         end
         if (lim_sel[k])
         begin
            rd_mux = interval_limit_reg[k];
         end
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         reg_rdata <= '0;
      end
      else if (reg_rd)
      begin
         reg_rdata <= rd_mux;
      end
      else
      begin
         reg_rdata <= '0;
      end
   end

endmodule
`default_nettype wire

/* sim/ict_timer_monitor.sv */
// Port assertions for the interval compare timer
`timescale 1ns/1ps
`default_nettype none
module ict_timer_monitor
   import ict_pkg::*;
#(
   parameter int NCH = ICT_NCH,
   parameter int DW = ICT_DW
)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic standby_in,
   input wire logic [ICT_AW-1:0] reg_addr,
   input wire logic [DW-1:0] reg_wdata,
   input wire logic [ICT_BE_W-1:0] reg_be,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DW-1:0] reg_rdata,
   input wire logic [NCH-1:0] match_interrupt
);
   logic clr0_reg;
   default clocking cb @(posedge clk_sys);
   endclocking
   // Only a status write, reset or standby may drop line zero
   always_ff @(posedge clk_sys)
   begin
      clr0_reg <= reset | standby_in |
         (reg_wr & reg_be[0] & (reg_addr == 4'h2));
   end
   a_reset_quiet: assert property (
      reset |=> reg_rdata == 16'h0000 && match_interrupt == 2'b00)
      else $error("reset left data or request set");
   a_csr_rsv_zero: assert property (disable iff (reset)
      reg_rd && reg_addr[2:0] == 3'h2 |=>
      reg_rdata[15:8] == 8'h00 && reg_rdata[5:2] == 4'h0)
      else $error("status reserved bits not zero");
   a_run_rsv_zero: assert property (disable iff (reset)
      reg_rd && reg_addr == 4'h0 |=> reg_rdata[15:2] == 14'h0000)
      else $error("run reserved bits not zero");
   a_lim_after_rst: assert property (disable iff (reset)
      $past(reset) && reg_rd && reg_addr == 4'h6 |=> reg_rdata == 16'hFFFF)
      else $error("limit not all ones after reset");
   a_ie_off_ch0: assert property (disable iff (reset)
      reg_wr && reg_be[0] && reg_addr == 4'h2 && !reg_wdata[6] |=>
      !match_interrupt[0])
      else $error("line zero high with enable off");
   a_ie_off_ch1: assert property (disable iff (reset)
      reg_wr && reg_be[0] && reg_addr == 4'hA && !reg_wdata[6] |=>
      !match_interrupt[1])
      else $error("line one high with enable off");
   a_irq_holds: assert property (disable iff (reset)
      $fell(match_interrupt[0]) |-> clr0_reg)
      else $error("line zero dropped without a clear");
   a_unmapped_zero: assert property (disable iff (reset)
      reg_rd && reg_addr[0] |=> reg_rdata == 16'h0000)
      else $error("odd address read not zero");
   c_irq0_rise: cover property ($rose(match_interrupt[0]));
   c_irq1_rise: cover property ($rose(match_interrupt[1]));
   c_standby_hit: cover property (standby_in && match_interrupt[0]);
endmodule
bind ict_timer ict_timer_monitor #(.NCH(NCH), .DW(DW)) i_ict_timer_monitor (
   .clk_sys, .reset, .standby_in, .reg_addr, .reg_wdata, .reg_be,
   .reg_wr, .reg_rd, .reg_rdata, .match_interrupt);
`default_nettype wire

/* sim/ict_irq_model.sv */
// Interrupt controller stand-in timing rises of line zero
`timescale 1ns/1ps
`default_nettype none
module ict_irq_model (
   input wire logic clk_sys,
   input wire logic [1:0] irq,
   output int rise_cnt,
   output int gap
);
   logic irq0_reg = 1'b0;
   int age = 0;
   // only line zero is sampled; line one is ignored
   always @(posedge clk_sys)
   begin
      irq0_reg <= irq[0];
      age <= age + 1;
      if (irq[0] && !irq0_reg)
      begin
         rise_cnt <= rise_cnt + 1;
         gap <= age;
         age <= 1;
      end
   end
endmodule
`default_nettype wire

/* sim/ict_timer_tb_top.sv */
// Self-checking bench for the interval compare timer
`timescale 1ns/1ps
`default_nettype none
module ict_timer_tb_top;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic standby_in = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic [1:0] reg_be = 2'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [1:0] match_interrupt;
   int rise_cnt;
   int gap;
   int n_mismatch = 0;
   int checks_done = 0;
   int n_hit = 0;
   int mreg [16];
   logic [15:0] d;
   logic [15:0] w;
   logic [15:0] v;
   logic [3:0] a;
   logic [1:0] b;
   ict_timer i_ict_timer (.clk_sys, .reset, .standby_in, .reg_addr,
      .reg_wdata, .reg_be, .reg_wr, .reg_rd, .reg_rdata, .match_interrupt);
   ict_irq_model i_ict_irq_model (.clk_sys, .irq(match_interrupt),
      .rise_cnt, .gap);
   always #5 clk_sys = ~clk_sys;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [3:0] ad, input logic [15:0] wd,
      input logic [1:0] be, input logic w_en, input logic r_en);
      reg_addr <= ad;
      reg_wdata <= wd;
      reg_be <= be;
      reg_wr <= w_en;
      reg_rd <= r_en;
      @(posedge clk_sys);
   endtask
   task automatic idle();
      op(4'h0, 16'h0000, 2'h0, 1'b0, 1'b0);
   endtask
   task automatic rd(input logic [3:0] ad);
      op(ad, 16'h0000, 2'h0, 1'b0, 1'b1);
      #1;
      d = reg_rdata;
   endtask
   function automatic logic [15:0] mrg(input logic [15:0] o, n,
      input logic [1:0] be);
      return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
   endfunction
   // Writable bits per address; odd and spare places keep nothing
   task automatic mwr(input logic [3:0] ad, input logic [15:0] wd,
      input logic [1:0] be);
      logic [15:0] m;
      m = (ad[0] || ad == 4'h8) ? 16'h0000 : ad == 4'h0 ? 16'h0003 :
         ad[2:0] == 3'h2 ? 16'h0043 : 16'hFFFF;
      op(ad, wd, be, 1'b1, 1'b0);
      mreg[ad] = mrg(16'(mreg[ad]), wd, be) & m;
   endtask
   task automatic rdc(input logic [3:0] ad);
      rd(ad);
      chk(d, 16'(mreg[ad]));
   endtask
   task automatic rd_all();
      mreg = '{default: 0};
      mreg[6] = 16'hFFFF;
      mreg[14] = 16'hFFFF;
      for (int i = 6; i < 22; i++)
         rdc(4'(i));
   endtask
   task automatic wait_rise();
      int n;
      n = rise_cnt;
      idle();
      for (int k = 0; k < 3000 && rise_cnt == n; k++)
         @(posedge clk_sys);
      // A missing rise must not pass quietly
      if (rise_cnt == n)
      begin
         n_mismatch++;
         $display("Error %0t: no interrupt rise", $time);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      void'($urandom(91));
      repeat (2) @(posedge clk_sys);
      reset <= 1'b0;
      rd_all();
      repeat (8)
      begin
         a = 4'h2 + 4'($urandom_range(0, 3)) * 4'h4;
         b = 2'($urandom_range(1, 3));
         v = 16'($urandom);
         mwr(a, a[2] ? v | 16'h0101 : v & 16'h0043, b);
         rdc(a);
      end
      mwr(4'h3, 16'hFFFF, 2'h3);
      rdc(4'h3);
      mwr(4'hA, 16'h0040, 2'h1);
      mwr(4'hC, 16'h0010, 2'h3);
      mwr(4'hE, 16'h0010, 2'h3);
      idle();
      rd(4'hA);
      chk(d, 16'h00C0);
      chk({14'h0, match_interrupt}, 16'h0002);
      rd(4'hC);
      chk(d, 16'h0000);
      mwr(4'hA, 16'h0000, 2'h1);
      rd(4'hA);
      chk({14'h0, match_interrupt}, 16'h0000);
      mwr(4'h6, 16'hFFFF, 2'h3);
      mwr(4'h2, 16'h0000, 2'h1);
      mwr(4'h0, 16'h0001, 2'h1);
      // Three-cycle steps walk every phase of the divide by 8
      repeat (8)
      begin
         w = 16'($urandom) & 16'h7FFF;
         v = 16'($urandom);
         b = 2'($urandom_range(1, 2));
         op(4'h4, w, 2'h3, 1'b1, 1'b0);
         op(4'h4, v, b, 1'b1, 1'b0);
         rd(4'h4);
         chk(d, mrg(w, v, b));
      end
      mwr(4'h6, 16'h0001, 2'h3);
      mwr(4'h4, 16'h0000, 2'h3);
      for (int s = 0; s < 4; s++)
      begin
         w = 16'h0040 | 16'(s);
         mwr(4'h2, w, 2'h1);
         wait_rise();
         rd(4'h2);
         chk(d, w | 16'h0080);
         mwr(4'h2, w, 2'h1);
         wait_rise();
         chk(16'(gap), 16'h0010 << (2 * s));
         chk({14'h0, match_interrupt}, 16'h0001);
      end
      standby_in <= 1'b1;
      idle();
      idle();
      standby_in <= 1'b0;
      rd_all();
      chk({14'h0, match_interrupt}, 16'h0000);
      // Counter write right after a write equal to the limit
      mwr(4'hE, 16'h0005, 2'h3);
      mwr(4'h0, 16'h0002, 2'h1);
      // Five-cycle steps meet each phase of the divide by 8 once
      repeat (8)
      begin
         op(4'hC, 16'h0005, 2'h3, 1'b1, 1'b0);
         op(4'hC, 16'h0105, 2'h3, 1'b1, 1'b0);
         rd(4'hC);
         w = d;
         rd(4'hA);
         chk(w, d[7] ? 16'h0000 : 16'h0105);
         n_hit += int'(d[7]);
         mwr(4'hA, 16'h0000, 2'h1);
      end
      chk(16'(n_hit), 16'h0001);
      mwr(4'hE, 16'h0001, 2'h3);
      mwr(4'hC, 16'h0000, 2'h3);
      mwr(4'hA, 16'h0040, 2'h1);
      repeat (20) idle();
      chk({14'h0, match_interrupt}, 16'h0002);
      mwr(4'h0, 16'h0003, 2'h1);
      reset <= 1'b1;
      idle();
      idle();
      reset <= 1'b0;
      rd_all();
      final_report();
   end
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      final_report();
   end
endmodule
`default_nettype wire
